// ---- sim/lcd_panel_model.sv ----
// Passive segment LCD panel that watches the driver pins.
`timescale 1ns/100ps
`default_nettype none
module lcd_panel_model (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [3:0]  common_pin,
  input  wire logic        pins_grounded,
  output var  logic [15:0] frame_cnt
);
  logic common_pin_prev;
  // Counts each new addressing of the first common, one per visible frame except in static duty.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      common_pin_prev <= 1'b0;
      frame_cnt <= 16'h0000;
    end else begin
      common_pin_prev <= common_pin[0];
      if (common_pin[0] && !common_pin_prev && !pins_grounded) begin
        frame_cnt <= frame_cnt + 16'h0001;
      end
    end
  end
endmodule // lcd_panel_model
`default_nettype wire

// ---- sim/segment_lcd_frame_control_tb.sv ----
// Self-checking bench of the segment LCD frame controller.
`timescale 1ns/100ps
`default_nettype none
`include "lcd_frame_consts.svh"
module segment_lcd_frame_control_tb;
  logic        clock = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, seed = 32'hd1ce;
  logic        wb_ack_o, frame_irq, ext_clock_buffer_en, lcd_clock_run, pol, pol0;
  logic [2:0]  sleep_mode = 3'h0, pm;
  logic        irq_vector_taken = 1'b0, timer_osc_in_pin = 1'b0;
  logic [24:0] segment_pin, segment_lcd_mode, mem [4];
  logic [3:0]  common_pin, common_lcd_mode, prev;
  logic        pins_grounded, wave_polarity, low_power_wave;
  logic [1:0]  bias_code;
  logic [7:0]  contrast_level, cv;
  logic [15:0] frame_cnt, fc;
  int          error_cnt = 0, checked = 0, n, tg;
  always #5 clock = ~clock;
  always @(posedge clock) timer_osc_in_pin <= ~timer_osc_in_pin;
  segment_lcd_frame_control segment_lcd_frame_control_inst (.clock, .arst_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .sleep_mode, .irq_vector_taken, .timer_osc_in_pin, .frame_irq, .ext_clock_buffer_en,
    .lcd_clock_run, .segment_pin, .common_pin, .segment_lcd_mode, .common_lcd_mode,
    .pins_grounded, .wave_polarity, .low_power_wave, .bias_code, .contrast_level);
  lcd_panel_model lcd_panel_model_inst (.clock, .arst_n, .common_pin, .pins_grounded,
    .frame_cnt);
  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [24:0] seg_mask(input logic [2:0] p);
    return 25'((64'h1 << ((p == 3'h7) ? 25 : (p == 3'h6) ? 24 : 13 + 2 * p)) - 64'h1);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic fail_wait;
    error_cnt++;
    end_sim();
  endtask
  task automatic bus(input logic we, input logic [5:0] ofs, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {ofs, 2'b00};
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) fail_wait();
    @(posedge clock);
  endtask
  task automatic clear_flag;
    n = 0;
    while (frame_irq !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    if (n >= 300) fail_wait();
    irq_vector_taken <= 1'b1;
    @(posedge clock);
    irq_vector_taken <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic poll_flag;
    tg = 0;
    do begin
      bus(1'b0, `LCD_OFS_CTRL_A, 32'h0);
      tg++;
    end while (rd[`LCD_A_FLAG] !== 1'b1 && tg < 100);
    if (tg >= 100) fail_wait();
  endtask
  task automatic watch(input int d, input logic [24:0] m);
    prev = 4'h0;
    repeat (40) begin
      @(posedge clock);
      if (common_pin !== prev && prev !== 4'h0) begin
        check("com_order", 32'(common_pin), 32'(prev[d] ? 4'h1 : 4'(prev << 1)));
      end
      for (int k = 0; k < 4; k++) begin
        if (common_pin === 4'(1 << k)) begin
          check("segments", 32'(segment_pin & m), 32'(mem[k] & m));
        end
      end
      prev = common_pin;
    end
    check("com_seen", 32'(|prev), 32'h1);
  endtask
  // ****************************************************************
  // Stimulus and checks.
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    check("pin_modes", {3'h0, segment_lcd_mode, common_lcd_mode}, 32'h0);
    for (int a = 0; a < 7; a++) begin
      bus(1'b0, (a == 6) ? 6'h3f : 6'(a), 32'h0);
      check("reset_reg", rd, (a == 2) ? 32'(`LCD_SLOT_RESET) : 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      mem[k] = (k == 3) ? 25'h1ffffff : seed[24:0];
      bus(1'b1, 6'(`LCD_OFS_MEM0 + k), {7'h0, mem[k]});
    end
    bus(1'b1, `LCD_OFS_SLOT_LEN, 32'h1);
    for (int d = 0; d < 4; d++) begin
      seed = lfsr(seed);
      pm = (d == 3) ? 3'h7 : seed[2:0];
      bus(1'b1, `LCD_OFS_CTRL_A, 32'h0);
      bus(1'b1, `LCD_OFS_CTRL_B, {25'h0, seed[6], 2'(d), 1'b0, pm});
      bus(1'b1, `LCD_OFS_CTRL_A, 32'h80);
      repeat (2) @(posedge clock);
      check("com_mode", 32'(common_lcd_mode), 32'(4'hf >> (3 - d)));
      check("seg_mode", 32'(segment_lcd_mode), 32'(seg_mask(pm)));
      check("bias", 32'(bias_code), (d == 0) ? 32'h0 : seed[6] ? 32'h1 : 32'h2);
      watch(d, seg_mask(pm));
    end
    bus(1'b1, `LCD_OFS_SLOT_LEN, 32'h7);
    bus(1'b1, `LCD_OFS_CTRL_A, 32'h88);
    seed = lfsr(seed);
    cv = seed[7:0];
    bus(1'b1, `LCD_OFS_CONTRAST, {24'h0, cv});
    for (int lp = 0; lp < 2; lp++) begin
      clear_flag();
      bus(1'b1, `LCD_OFS_CTRL_A, 32'h88 | (lp << 6));
      pol = wave_polarity;
      pol0 = wave_polarity;
      n = 0;
      while (low_power_wave !== 1'(lp) && n < 100) begin
        pol0 = pol;
        pol = wave_polarity;
        @(posedge clock);
        n++;
      end
      if (n >= 100) fail_wait();
      if (lp == 1) check("wave_switch", 32'(pol ^ pol0), 32'h1);
      clear_flag();
      check("irq_cleared", 32'(frame_irq), 32'h0);
      tg = 0;
      pol = wave_polarity;
      n = 0;
      while (frame_irq !== 1'b1 && n < 300) begin
        @(posedge clock);
        tg += int'(wave_polarity !== pol);
        pol = wave_polarity;
        n++;
      end
      if (n >= 300) fail_wait();
      check("frames_per_flag", tg, lp + 1);
      check("contrast", 32'(contrast_level), 32'(cv));
    end
    bus(1'b1, `LCD_OFS_CTRL_A, 32'h88);
    clear_flag();
    poll_flag();
    bus(1'b1, `LCD_OFS_CTRL_A, 32'h99);
    check("blank_early", 32'(pins_grounded), 32'h0);
    bus(1'b0, `LCD_OFS_CTRL_A, 32'h0);
    check("ctrl_a", rd, 32'h89);
    poll_flag();
    repeat (2) @(posedge clock);
    check("grounded", {2'h0, pins_grounded, segment_pin, common_pin}, 32'h20000000);
    fc = frame_cnt;
    bus(1'b0, 6'(`LCD_OFS_MEM0 + 1), 32'h0);
    check("mem_kept", rd, {7'h0, mem[1]});
    repeat (80) @(posedge clock);
    check("panel_frames", 32'(frame_cnt), 32'(fc));
    bus(1'b1, `LCD_OFS_CTRL_A, 32'h0);
    repeat (2) @(posedge clock);
    check("released", {3'h0, segment_lcd_mode, common_lcd_mode}, 32'h0);
    bus(1'b1, `LCD_OFS_SLOT_LEN, 32'h1);
    for (int cs = 0; cs < 2; cs++) begin
      bus(1'b1, `LCD_OFS_CTRL_A, 32'h0);
      bus(1'b1, `LCD_OFS_CTRL_B, 32'h37 | (cs << 7));
      bus(1'b1, `LCD_OFS_CTRL_A, 32'h80);
      for (int ex = 0; ex < 2; ex++) begin
        bus(1'b1, `LCD_OFS_ASYNC, 32'(ex));
        repeat (2) @(posedge clock);
        check("ext_buffer", 32'(ext_clock_buffer_en), 32'(cs & ex));
      end
      fc = frame_cnt;
      repeat (200) @(posedge clock);
      check("frames_run", 32'(frame_cnt != fc), 32'h1);
      for (int m = 0; m < 6; m++) begin
        if (cs == 0 && (m == 2 || m == 3 || m == 5)) begin
          bus(1'b1, `LCD_OFS_CTRL_A, 32'h0);
        end
        sleep_mode <= 3'(m);
        repeat (3) @(posedge clock);
        check("clock_run", 32'(lcd_clock_run), 32'(m < 2 || m == 4 || (cs && m == 2)));
        sleep_mode <= 3'h0;
        bus(1'b1, `LCD_OFS_CTRL_A, 32'h80);
      end
    end
    end_sim();
  end
endmodule // segment_lcd_frame_control_tb
`default_nettype wire

// ---- src/lcd_frame_consts.svh ----
// Offsets, field positions, reset values and pin counts of the segment LCD frame controller.
// What this block does
// - Two-common duty supports both half bias and one-third bias drive.
// - Three- and four-common duty are driven with one-third bias available.
// - Low power waveform latches data and raises frame flag every second frame.
// - Synchronous LCD clock keeps display running in idle and power-save sleep.
// - Timer oscillator clock keeps display running in idle, ADC-noise and power-save.
// - External clock bit with asynchronous clock selected enables external clock buffer.
// - Blanking waits for the next frame start with data update, then grounds all pins, memory kept.
// - Port mask releases unused segment pins to ordinary port function.
// - Common pins unused by the selected duty revert to port function.
// - Memory, blanking and contrast are latched just before each frame with data update; waveform before every frame.
// - Disabled controller returns segment and common pins to port function.
// - Frame flag set at frame start with data update; cleared by one or vector.
// - Waveform selection change takes effect at the next frame start.
// - Duty select 00..11 means static, 1/2, 1/3, 1/4 using commons 0..3.
// - Outside static duty, half bias select one gives half bias, zero gives one-third bias.
`ifndef LCD_FRAME_CONSTS_SVH
`define LCD_FRAME_CONSTS_SVH
// ****************************************************************
// Register offsets.
// ****************************************************************
`define LCD_OFS_CTRL_A    6'h00
`define LCD_OFS_CTRL_B    6'h01
`define LCD_OFS_SLOT_LEN  6'h02
`define LCD_OFS_CONTRAST  6'h03
`define LCD_OFS_ASYNC     6'h04
`define LCD_OFS_STATUS    6'h05
`define LCD_OFS_MEM0      6'h08
// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define LCD_A_EN          7
`define LCD_A_LP          6
`define LCD_A_FLAG        4
`define LCD_A_IE          3
`define LCD_A_BD          2
`define LCD_A_CCD         1
`define LCD_A_BL          0
`define LCD_B_CS          7
`define LCD_B_HB          6
`define LCD_ASYNC_EXT     0
`define LCD_SLOT_RESET    8'h10
`define LCD_SEGS          25
`define LCD_COMS          4
`endif

// ---- src/lcd_frame_pkg.sv ----
// Types shared by the segment LCD frame controller.
package lcd_frame_pkg;
  typedef enum logic [2:0] {
    sleep_active     = 3'b000,
    sleep_idle       = 3'b001,
    sleep_adc_nr     = 3'b010,
    sleep_power_down = 3'b011,
    sleep_power_save = 3'b100,
    sleep_standby    = 3'b101
  } sleep_mode_e;
  typedef enum logic {
    st_off = 1'b0,
    st_run = 1'b1
  } lcd_state_e;
  typedef enum logic [1:0] {
    bias_static = 2'b00,
    bias_half   = 2'b01,
    bias_third  = 2'b10
  } bias_e;
endpackage

// ---- src/segment_lcd_frame_control.sv ----
// Frame timing, latching, blanking and pin ownership of a passive segment LCD driver.
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "lcd_frame_consts.svh"
module segment_lcd_frame_control (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic [2:0]  sleep_mode,
  input  wire logic        irq_vector_taken,
  input  wire logic        timer_osc_in_pin,
  output var  logic        frame_irq,
  output var  logic        ext_clock_buffer_en,
  output var  logic        lcd_clock_run,
  output var  logic [24:0] segment_pin,
  output var  logic [3:0]  common_pin,
  output var  logic [24:0] segment_lcd_mode,
  output var  logic [3:0]  common_lcd_mode,
  output var  logic        pins_grounded,
  output var  logic        wave_polarity,
  output var  logic        low_power_wave,
  output var  logic [1:0]  bias_code,
  output var  logic [7:0]  contrast_level
);
  // ****************************************************************
  // Decoding helpers.
  // ****************************************************************
  function automatic logic [3:0] com_mask(input logic [1:0] duty_select);
    com_mask = 4'hf >> (2'h3 - duty_select);
  endfunction
  function automatic logic [24:0] seg_mask(input logic [2:0] port_mask_select);
    unique case (port_mask_select)
      3'h0: seg_mask = 25'h0001fff;
      3'h1: seg_mask = 25'h0007fff;
      3'h2: seg_mask = 25'h001ffff;
      3'h3: seg_mask = 25'h007ffff;
      3'h4: seg_mask = 25'h01fffff;
      3'h5: seg_mask = 25'h07fffff;
      3'h6: seg_mask = 25'h0ffffff;
      3'h7: seg_mask = 25'h1ffffff;
    endcase
  endfunction
  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [7:0]  ctrl_a;
  logic [7:0]  ctrl_b;
  logic [7:0]  slot_len;
  logic [7:0]  contrast_ctrl_reg;
  logic        async_status_reg;
  logic [24:0] segment_memory [0:3];
  logic [24:0] mem_latched [0:3];
  logic        blank_latched;
  logic        lp_latched;
  logic        parity;
  logic [1:0]  com_idx;
  logic [7:0]  slot_cnt;
  logic        osc_meta;
  logic        osc_sync;
  logic        osc_prev;
  lcd_frame_pkg::lcd_state_e state;
  logic        access;
  logic        wr;
  logic        display_driver_on;
  logic        async_clock_sel;
  logic [1:0]  duty_select;
  logic        clock_ok;
  logic        tick;
  logic        slot_end;
  logic        frame_start;
  logic        latch_now;
  logic        flag_clear;
  logic [31:0] next_rdata;
  assign access            = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr                = access & wb_we_i & wb_sel_i[0];
  assign display_driver_on = ctrl_a[`LCD_A_EN];
  assign async_clock_sel   = ctrl_b[`LCD_B_CS];
  assign duty_select       = ctrl_b[5:4];
  // ****************************************************************
  // Bus slave.
  // ****************************************************************
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (wb_adr_i[7:2] >= `LCD_OFS_MEM0 && wb_adr_i[7:2] < `LCD_OFS_MEM0 + 6'h04) begin
      next_rdata = {7'h00, segment_memory[wb_adr_i[3:2]]};
    end else begin
      unique case (wb_adr_i[7:2])
        `LCD_OFS_CTRL_A:   next_rdata = {24'h000000, ctrl_a & 8'hdf};
        `LCD_OFS_CTRL_B:   next_rdata = {24'h000000, ctrl_b & 8'hf7};
        `LCD_OFS_SLOT_LEN: next_rdata = {24'h000000, slot_len};
        `LCD_OFS_CONTRAST: next_rdata = {24'h000000, contrast_ctrl_reg};
        `LCD_OFS_ASYNC:    next_rdata = {31'h00000000, async_status_reg};
        `LCD_OFS_STATUS:   next_rdata = {27'h0000000, blank_latched, parity, state, com_idx};
        default:           next_rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= access ? next_rdata : 32'h0000_0000;
    end
  end
  assign flag_clear = (wr && wb_adr_i[7:2] == `LCD_OFS_CTRL_A && wb_dat_i[`LCD_A_FLAG])
                      || irq_vector_taken;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_a            <= 8'h00;
      ctrl_b            <= 8'h00;
      slot_len          <= `LCD_SLOT_RESET;
      contrast_ctrl_reg <= 8'h00;
      async_status_reg  <= 1'b0;
    end else begin
      if (wr && wb_adr_i[7:2] == `LCD_OFS_CTRL_A) begin
        ctrl_a[7:5] <= wb_dat_i[7:5];
        ctrl_a[3:0] <= wb_dat_i[3:0];
      end
      if (latch_now) begin
        ctrl_a[`LCD_A_FLAG] <= 1'b1;
      end else if (flag_clear) begin
        ctrl_a[`LCD_A_FLAG] <= 1'b0;
      end
      if (wr && wb_adr_i[7:2] == `LCD_OFS_CTRL_B) begin
        ctrl_b <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i[7:2] == `LCD_OFS_SLOT_LEN) begin
        slot_len <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i[7:2] == `LCD_OFS_CONTRAST) begin
        contrast_ctrl_reg <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i[7:2] == `LCD_OFS_ASYNC) begin
        async_status_reg <= wb_dat_i[`LCD_ASYNC_EXT];
      end
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `LCD_COMS; i++) begin
        segment_memory[i] <= 25'h0000000;
      end
    end else if (wr && wb_adr_i[7:2] >= `LCD_OFS_MEM0
                 && wb_adr_i[7:2] < `LCD_OFS_MEM0 + 6'h04) begin
      segment_memory[wb_adr_i[3:2]] <= wb_dat_i[24:0];
    end
  end
  // ****************************************************************
  // Clock source and sleep behaviour.
  // ****************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= timer_osc_in_pin;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end
  always_comb begin
    if (async_clock_sel) begin
      clock_ok = sleep_mode == lcd_frame_pkg::sleep_active || sleep_mode == lcd_frame_pkg::sleep_idle
                 || sleep_mode == lcd_frame_pkg::sleep_adc_nr
                 || sleep_mode == lcd_frame_pkg::sleep_power_save;
    end else begin
      clock_ok = sleep_mode == lcd_frame_pkg::sleep_active || sleep_mode == lcd_frame_pkg::sleep_idle
                 || sleep_mode == lcd_frame_pkg::sleep_power_save;
    end
  end
  assign tick = clock_ok & (async_clock_sel ? (osc_sync & ~osc_prev) : 1'b1);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ext_clock_buffer_en <= 1'b0;
      lcd_clock_run       <= 1'b0;
    end else begin
      ext_clock_buffer_en <= async_status_reg & async_clock_sel;
      lcd_clock_run       <= display_driver_on & clock_ok;
    end
  end
  // ****************************************************************
  // Frame sequencer.
  // ****************************************************************
  assign slot_end    = state == lcd_frame_pkg::st_run && tick && slot_cnt >= slot_len;
  assign frame_start = (state == lcd_frame_pkg::st_off && display_driver_on)
                       || (slot_end && com_idx >= duty_select && display_driver_on);
  assign latch_now   = frame_start && (!ctrl_a[`LCD_A_LP] || !parity);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state    <= lcd_frame_pkg::st_off;
      com_idx  <= 2'h0;
      slot_cnt <= 8'h00;
    end else if (!display_driver_on) begin
      state    <= lcd_frame_pkg::st_off;
      com_idx  <= 2'h0;
      slot_cnt <= 8'h00;
    end else begin
      unique case (state)
        lcd_frame_pkg::st_off: begin
          state <= lcd_frame_pkg::st_run;
        end
        lcd_frame_pkg::st_run: begin
          if (slot_end) begin
            slot_cnt <= 8'h00;
            com_idx  <= frame_start ? 2'h0 : com_idx + 2'h1;
          end else if (tick) begin
            slot_cnt <= slot_cnt + 8'h01;
          end
        end
      endcase
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      parity        <= 1'b0;
      lp_latched    <= 1'b0;
      blank_latched <= 1'b0;
      wave_polarity <= 1'b0;
      contrast_level <= 8'h00;
      for (int i = 0; i < `LCD_COMS; i++) begin
        mem_latched[i] <= 25'h0000000;
      end
    end else if (frame_start) begin
      lp_latched    <= ctrl_a[`LCD_A_LP];
      parity        <= ctrl_a[`LCD_A_LP] ? ~parity : 1'b0;
      wave_polarity <= ~wave_polarity;
      if (latch_now) begin
        blank_latched  <= ctrl_a[`LCD_A_BL];
        contrast_level <= contrast_ctrl_reg;
        for (int i = 0; i < `LCD_COMS; i++) begin
          mem_latched[i] <= segment_memory[i];
        end
      end
    end
  end
  // ****************************************************************
  // Pin drive.
  // ****************************************************************
  logic        running;
  logic        dark;
  logic [24:0] seg_owned;
  assign seg_owned = seg_mask(ctrl_b[2:0]);
  assign running = display_driver_on && state == lcd_frame_pkg::st_run;
  assign dark    = !running || blank_latched;
  generate
    for (genvar s = 0; s < `LCD_SEGS; s++) begin : g_seg
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          segment_pin[s]      <= 1'b0;
          segment_lcd_mode[s] <= 1'b0;
        end else begin
          segment_lcd_mode[s] <= display_driver_on & seg_owned[s];
          segment_pin[s]      <= !dark & mem_latched[com_idx][s];
        end
      end
    end
  endgenerate
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      common_pin      <= 4'h0;
      common_lcd_mode <= 4'h0;
      pins_grounded   <= 1'b0;
      frame_irq       <= 1'b0;
      low_power_wave  <= 1'b0;
      bias_code       <= lcd_frame_pkg::bias_static;
    end else begin
      common_lcd_mode <= display_driver_on ? com_mask(duty_select) : 4'h0;
      common_pin      <= dark ? 4'h0 : 4'h1 << com_idx;
      pins_grounded   <= running & blank_latched;
      frame_irq       <= ctrl_a[`LCD_A_FLAG] & ctrl_a[`LCD_A_IE];
      low_power_wave  <= lp_latched;
      if (duty_select == 2'h0) begin
        bias_code <= lcd_frame_pkg::bias_static;
      end else if (ctrl_b[`LCD_B_HB]) begin
        bias_code <= lcd_frame_pkg::bias_half;
      end else begin
        bias_code <= lcd_frame_pkg::bias_third;
      end
    end
  end
  // ****************************************************************
  // Checks.
  // ****************************************************************
  chk_flag_on_latch: assert property (@(posedge clock) disable iff (!arst_n)
    latch_now |=> ctrl_a[`LCD_A_FLAG]) else $error("Frame flag not set at latch.");
  chk_lp_skip: assert property (@(posedge clock) disable iff (!arst_n)
    frame_start && ctrl_a[`LCD_A_LP] && parity
    |=> $stable(contrast_level) && $stable(blank_latched) && $stable(mem_latched[0]))
    else $error("Low power waveform latched on odd frame.");
  chk_flag_clear: assert property (@(posedge clock) disable iff (!arst_n)
    irq_vector_taken && !latch_now |=> !ctrl_a[`LCD_A_FLAG])
    else $error("Frame flag not cleared.");
  chk_blank_ground: assert property (@(posedge clock) disable iff (!arst_n)
    running && blank_latched |=> segment_pin == 25'h0 && common_pin == 4'h0 && pins_grounded)
    else $error("Blanked display still drives pins.");
  chk_off_port: assert property (@(posedge clock) disable iff (!arst_n)
    !display_driver_on |=> segment_lcd_mode == 25'h0 && common_lcd_mode == 4'h0)
    else $error("Disabled controller still owns pins.");
  chk_com_release: assert property (@(posedge clock) disable iff (!arst_n)
    display_driver_on |=> common_lcd_mode == com_mask($past(duty_select)))
    else $error("Common pin ownership wrong for duty.");
  chk_seg_mask: assert property (@(posedge clock) disable iff (!arst_n)
    display_driver_on && ctrl_b[2:0] == 3'h0 |=> segment_lcd_mode[24:13] == 12'h000)
    else $error("Masked segment pin still owned.");
  chk_half_bias: assert property (@(posedge clock) disable iff (!arst_n)
    duty_select == 2'h1 && ctrl_b[`LCD_B_HB] |=> bias_code == lcd_frame_pkg::bias_half)
    else $error("Half bias not applied.");
  chk_ext_buffer: assert property (@(posedge clock) disable iff (!arst_n)
    async_status_reg && async_clock_sel |=> ext_clock_buffer_en)
    else $error("External clock buffer not enabled.");
  chk_sync_sleep: assert property (@(posedge clock) disable iff (!arst_n)
    !async_clock_sel && sleep_mode == lcd_frame_pkg::sleep_power_down |-> !tick)
    else $error("Synchronous LCD clock ran in power-down.");
endmodule // segment_lcd_frame_control
`default_nettype wire
